/* File: design/virc_pkg.sv */
package virc_pkg;
    // ******************************
    // register map
    // ******************************
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam logic [11:0] OFS_REQ0        = 12'hFC0;
    localparam logic [11:0] OFS_REQ1        = 12'hFC3;
    localparam logic [11:0] OFS_REQ2        = 12'hFC6;
    localparam logic [11:0] OFS_EN0_HI      = 12'hFC1;
    localparam logic [11:0] OFS_EN0_LO      = 12'hFC2;
    localparam logic [11:0] OFS_EN1_HI      = 12'hFC4;
    localparam logic [11:0] OFS_EN1_LO      = 12'hFC5;
    localparam logic [11:0] OFS_EN2_HI      = 12'hFC7;
    localparam logic [11:0] OFS_EN2_LO      = 12'hFC8;
    localparam logic [11:0] OFS_CTRL        = 12'hFCF;
    localparam logic [11:0] OFS_ISTAT       = 12'hFD0;
    localparam logic [11:0] OFS_IMASK       = 12'hFD1;
    localparam logic [11:0] OFS_VECTOR      = 12'hFD2;
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam int          GATE_BIT        = 7;
    // ******************************
    // sources and levels
    // ******************************
    localparam int          NSRC            = 24;
    localparam int          SRC_W           = 5;
    localparam logic [4:0]  NO_SRC          = 5'h1F;
    localparam logic [1:0]  LVL_OFF         = 2'h0;
    // status bits of the local interrupt
    localparam int          EV_FORWARD      = 0;
    localparam int          EV_ACK          = 1;
    localparam int          EV_W            = 2;
endpackage

/* File: design/virc_src_slot.sv */
`timescale 1ns/1ps
module virc_src_slot
    import virc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic reqIn,
    input  wire logic swWrite,
    input  wire logic swValue,
    input  wire logic ackHit,
    output logic      pend
);
    logic reqSync1_r;
    logic reqSync2_r;
    logic pend_r;
    logic pend_nxt;

    // set beats software clear and ack so no event is lost
    always_comb begin
        pend_nxt = pend_r;
        if (swWrite) begin
            pend_nxt = swValue; // R14
        end else if (ackHit) begin
            pend_nxt = 1'b0; // R14
        end
        if (reqSync2_r) begin
            pend_nxt = 1'b1; // R4
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqSync1_r <= 1'b0;
            reqSync2_r <= 1'b0;
            pend_r     <= 1'b0;
        end else begin
            reqSync1_r <= reqIn;
            reqSync2_r <= reqSync1_r;
            pend_r     <= pend_nxt;
        end
    end

    assign pend = pend_r; // R9
endmodule

/* File: design/virc_prio_pick.sv */
`timescale 1ns/1ps
module virc_prio_pick
    import virc_pkg::*;
#(
    parameter int N = NSRC
)
(
    input  wire logic [N-1:0]   pendVec,
    input  wire logic [N-1:0]   enHi,
    input  wire logic [N-1:0]   enLo,
    output logic                found,
    output logic [SRC_W-1:0]    winner
);
    logic [1:0] bestLvl;
    logic [1:0] lvl;

    // highest level wins; ties go to the highest bit position
    always_comb begin
        found   = 1'b0;
        winner  = NO_SRC;
        bestLvl = LVL_OFF;
        lvl     = LVL_OFF;
        for (int i = 0; i < N; i++) begin
            lvl = {enHi[i], enLo[i]}; // R13
            if (pendVec[i] && lvl != LVL_OFF && (!found || lvl >= bestLvl)) begin
                found   = 1'b1;
                bestLvl = lvl;
                winner  = SRC_W'(i);
            end
        end
    end
endmodule

/* File: design/virc_top.sv */
`timescale 1ns/1ps
// What this block does
// R1: one master gate bit globally passes or blocks all latched requests to the core.
// R2: gate sets on enable instruction, return-from-interrupt, or software writing one.
// R3: gate clears on disable instruction, core acknowledge, software writing zero, or reset.
// R4: a peripheral request sets its bit in the request register.
// R5: with the gate set, pending requests go to the core as vectored requests.
// R6: with the gate clear, software polls request registers; nothing goes to the core.
// R7: watchdog interrupt bypasses these registers entirely.
// R8: request group 0 holds timers 2..0, serial0 rx/tx, twowire, serial periph, converter.
// R9: a request bit reads one while its source awaits service, else zero.
// R10: serial0 receive and transmit request bits act independently.
// R11: group 2 enable-high holds timer3, serial1 rx/tx, dma, port C3..C0 bits.
// R12: group 2 enable-low holds matching bits in the same order.
// R13: enable pair gives off or one of three levels; highest enabled pending wins.
// R14: acknowledge clears the serviced request bit; software writes set or clear bits.
module virc_top
    import virc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   regAddr,
    input  wire logic [DATA_W-1:0]   regWrData,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic      [DATA_W-1:0]   regRdData,
    input  wire logic [NSRC-1:0]     srcReq,
    input  wire logic                instrGlobalOn,
    input  wire logic                instrGlobalOff,
    input  wire logic                instrReturnFromIsr,
    input  wire logic                coreAck,
    output logic                     coreIrq,
    output logic      [SRC_W-1:0]    coreVector,
    output logic                     masterIrqGate,
    output logic                     irqOut
);
    // ******************************
    // request bits
    // ******************************
    // srcReq[7:0] is group 0 in the order timer2..converter, [15:8] group 1,
    // [23:16] group 2 in the order timer3, serial1 rx/tx, dma, port C3..C0
    // watchdog has no slot here; it reaches the core by its own path  // R7
    logic [NSRC-1:0]   pendVec;
    logic [NSRC-1:0]   swWr;
    logic [NSRC-1:0]   ackHit;
    logic [2:0]        reqGrpHit;
    // declared ahead of the slots because the ack decode reads them
    logic              coreIrq_r;
    logic              coreIrq_nxt;
    logic [SRC_W-1:0]  coreVector_r;
    logic [SRC_W-1:0]  coreVector_nxt;

    assign reqGrpHit = {regWrite && regAddr == OFS_REQ2,
                        regWrite && regAddr == OFS_REQ1,
                        regWrite && regAddr == OFS_REQ0}; // R8

    for (genvar i = 0; i < NSRC; i++) begin : gSlot
        assign swWr[i]   = reqGrpHit[i / DATA_W];
        assign ackHit[i] = coreAck && coreIrq_r && (coreVector_r == SRC_W'(i)); // R14
        virc_src_slot uSlot (
            .clk     (clk),
            .rst     (rst),
            .reqIn   (srcReq[i]),
            .swWrite (swWr[i]),
            .swValue (regWrData[i % DATA_W]),
            .ackHit  (ackHit[i]),
            .pend    (pendVec[i])
        ); // R4 R10
    end

    // ******************************
    // enables, gate, local interrupt
    // ******************************
    logic [NSRC-1:0]   enHi_r;
    logic [NSRC-1:0]   enHi_nxt;
    logic [NSRC-1:0]   enLo_r;
    logic [NSRC-1:0]   enLo_nxt;
    logic              gate_r;
    logic              gate_nxt;
    logic [EV_W-1:0]   istat_r;
    logic [EV_W-1:0]   istat_nxt;
    logic [EV_W-1:0]   imask_r;
    logic [EV_W-1:0]   imask_nxt;
    logic [DATA_W-1:0] rd_r;
    logic [DATA_W-1:0] rd_nxt;
    logic              irq_r;
    logic              irq_nxt;
    logic              found;
    logic [SRC_W-1:0]  winner;

    virc_prio_pick #(.N(NSRC)) uPick (
        .pendVec (pendVec),
        .enHi    (enHi_r),
        .enLo    (enLo_r),
        .found   (found),
        .winner  (winner)
    ); // R13

    always_comb begin
        enHi_nxt  = enHi_r;
        enLo_nxt  = enLo_r;
        gate_nxt  = gate_r;
        imask_nxt = imask_r;
        istat_nxt = istat_r;
        if (regWrite) begin
            unique case (regAddr)
                OFS_EN0_HI: enHi_nxt[0*DATA_W +: DATA_W] = regWrData;
                OFS_EN0_LO: enLo_nxt[0*DATA_W +: DATA_W] = regWrData;
                OFS_EN1_HI: enHi_nxt[1*DATA_W +: DATA_W] = regWrData;
                OFS_EN1_LO: enLo_nxt[1*DATA_W +: DATA_W] = regWrData;
                OFS_EN2_HI: enHi_nxt[2*DATA_W +: DATA_W] = regWrData; // R11
                OFS_EN2_LO: enLo_nxt[2*DATA_W +: DATA_W] = regWrData; // R12
                OFS_CTRL:   gate_nxt        = regWrData[GATE_BIT]; // R2 R3
                OFS_IMASK:  imask_nxt       = regWrData[EV_W-1:0];
                default:    ;
            endcase
        end
        // instructions act after a same-cycle register write
        if (instrGlobalOn || instrReturnFromIsr) begin
            gate_nxt = 1'b1; // R2
        end
        if (instrGlobalOff || (coreAck && coreIrq_r)) begin
            gate_nxt = 1'b0; // R3
        end
        // read clears status; new events win over the clear
        if (regRead && regAddr == OFS_ISTAT) begin
            istat_nxt = '0;
        end
        if (coreIrq_nxt && !coreIrq_r) begin
            istat_nxt[EV_FORWARD] = 1'b1;
        end
        if (coreAck && coreIrq_r) begin
            istat_nxt[EV_ACK] = 1'b1;
        end
    end

    // forward only while the gate is set; the vector follows the current winner every cycle, even while offered
    always_comb begin
        coreIrq_nxt    = gate_r && found && !(coreAck && coreIrq_r); // R1 R5 R6
        coreVector_nxt = found ? winner : NO_SRC;
        irq_nxt        = |(istat_nxt & imask_nxt);
    end

    always_comb begin
        rd_nxt = RST_BYTE;
        if (regRead) begin
            unique case (regAddr)
                OFS_REQ0:   rd_nxt = pendVec[0*DATA_W +: DATA_W]; // R9
                OFS_REQ1:   rd_nxt = pendVec[1*DATA_W +: DATA_W];
                OFS_REQ2:   rd_nxt = pendVec[2*DATA_W +: DATA_W];
                OFS_EN0_HI: rd_nxt = enHi_r[0*DATA_W +: DATA_W];
                OFS_EN0_LO: rd_nxt = enLo_r[0*DATA_W +: DATA_W];
                OFS_EN1_HI: rd_nxt = enHi_r[1*DATA_W +: DATA_W];
                OFS_EN1_LO: rd_nxt = enLo_r[1*DATA_W +: DATA_W];
                OFS_EN2_HI: rd_nxt = enHi_r[2*DATA_W +: DATA_W];
                OFS_EN2_LO: rd_nxt = enLo_r[2*DATA_W +: DATA_W];
                OFS_CTRL:   rd_nxt[GATE_BIT] = gate_r;
                OFS_ISTAT:  rd_nxt = DATA_W'(istat_r);
                OFS_IMASK:  rd_nxt = DATA_W'(imask_r);
                OFS_VECTOR: rd_nxt = DATA_W'(coreVector_r);
                default:    rd_nxt = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enHi_r       <= '0;
            enLo_r       <= '0;
            gate_r       <= 1'b0; // R3
            istat_r      <= '0;
            imask_r      <= '0;
            coreIrq_r    <= 1'b0;
            coreVector_r <= NO_SRC;
            rd_r         <= RST_BYTE;
            irq_r        <= 1'b0;
        end else begin
            enHi_r       <= enHi_nxt;
            enLo_r       <= enLo_nxt;
            gate_r       <= gate_nxt;
            istat_r      <= istat_nxt;
            imask_r      <= imask_nxt;
            coreIrq_r    <= coreIrq_nxt;
            coreVector_r <= coreVector_nxt;
            rd_r         <= rd_nxt;
            irq_r        <= irq_nxt;
        end
    end

    assign regRdData     = rd_r;
    assign coreIrq       = coreIrq_r;
    assign coreVector    = coreVector_r;
    assign masterIrqGate = gate_r;
    assign irqOut        = irq_r;
endmodule

/* File: bench/virc_core_model.sv */
`timescale 1ns/1ps
// ****
// core side: acks a vectored request ackDelay+1 cycles after it rises
// ****
module virc_core_model (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       coreIrq,
    input wire logic [3:0] ackDelay,
    output logic           coreAck
);
    logic [3:0] waitCnt;
    // one-cycle ack, never while the request is down
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            coreAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (coreAck || !coreIrq) begin
            coreAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (waitCnt == ackDelay) begin
            coreAck <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

/* File: bench/virc_chk.sv */
`timescale 1ns/1ps
// ****
// gate, core link and unmapped read checks
// ****
module virc_chk
    import virc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic              instrGlobalOn,
    input wire logic              instrGlobalOff,
    input wire logic              instrReturnFromIsr,
    input wire logic              coreAck,
    input wire logic              coreIrq,
    input wire logic [SRC_W-1:0]  coreVector,
    input wire logic              masterIrqGate
);
    logic ackHit;
    logic anyInstr;
    assign ackHit   = coreAck && coreIrq;
    assign anyInstr = instrGlobalOn || instrGlobalOff || instrReturnFromIsr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence sTake;
        ackHit;
    endsequence
    sequence sDrop;
        !coreIrq && !masterIrqGate;
    endsequence
    AST_ACK: assert property (sTake |=> sDrop)
        else $error("ack left gate or request up");
    AST_OFF: assert property (instrGlobalOff |=> !masterIrqGate)
        else $error("gate up after disable");
    AST_ON: assert property ((instrGlobalOn || instrReturnFromIsr) && !instrGlobalOff && !ackHit
        |=> masterIrqGate) else $error("gate down after enable");
    AST_WR: assert property (regWrite && regAddr == OFS_CTRL && !anyInstr && !ackHit
        |=> masterIrqGate == $past(regWrData[GATE_BIT])) else $error("gate not as written");
    AST_BLOCK: assert property (!masterIrqGate [*2] |-> !coreIrq)
        else $error("request passed a closed gate");
    AST_VEC: assert property (coreIrq |-> coreVector != NO_SRC)
        else $error("request without source");
    AST_FWD: assert property ($rose(coreIrq) |-> $past(masterIrqGate) || masterIrqGate)
        else $error("request raised with gate closed");
    AST_UNMAP: assert property (regRead && regAddr == 12'hFFF |=> regRdData == RST_BYTE)
        else $error("unmapped read not zero");
endmodule
bind virc_top virc_chk u_chk (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .instrGlobalOn(instrGlobalOn),
    .instrGlobalOff(instrGlobalOff), .instrReturnFromIsr(instrReturnFromIsr), .coreAck(coreAck),
    .coreIrq(coreIrq), .coreVector(coreVector), .masterIrqGate(masterIrqGate));

/* File: bench/vectored_interrupt_request_ctrl_test.sv */
`timescale 1ns/1ps
module vectored_interrupt_request_ctrl_test
    import virc_pkg::*;
;
    // ****
    // register access, polling, vectoring
    // ****
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] regAddr = 12'h000;
    logic [DATA_W-1:0] regWrData = 8'h00;
    logic              regWrite = 1'b0;
    logic              regRead = 1'b0;
    logic [NSRC-1:0]   srcReq = 24'h000000;
    logic [2:0]        instr = 3'h0;
    logic [3:0]        ackDelay = 4'h3;
    logic [DATA_W-1:0] regRdData;
    logic [SRC_W-1:0]  coreVector;
    logic              coreAck;
    logic              coreIrq;
    logic              masterIrqGate;
    logic              irqOut;
    int                n_mismatch = 0;
    int                total_checks = 0;
    logic [11:0]       regs [3] = '{OFS_REQ0, OFS_EN2_HI, OFS_EN2_LO};
    always #2.5 clk = ~clk;
    virc_top DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .srcReq(srcReq), .instrGlobalOn(instr[2]),
        .instrGlobalOff(instr[1]), .instrReturnFromIsr(instr[0]), .coreAck(coreAck), .coreIrq(coreIrq),
        .coreVector(coreVector), .masterIrqGate(masterIrqGate), .irqOut(irqOut));
    virc_core_model core (.clk(clk), .rst(rst), .coreIrq(coreIrq), .ackDelay(ackDelay), .coreAck(coreAck));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask
    task automatic pulse(input logic [2:0] v, input logic exp);
        @(posedge clk);
        instr <= v;
        @(posedge clk);
        instr <= 3'h0;
        #1;
        chk(8'(masterIrqGate), 8'(exp));
    endtask
    // bounded wait for the core ack, then the vector it took
    task automatic waitAck(input logic [7:0] vec);
        for (int i = 0; i < 60 && coreAck !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (coreAck !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end else begin
            chk(8'(coreVector), vec);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) begin
            rd(regs[i], RST_BYTE);
            wr(regs[i], 8'hA5);
            rd(regs[i], 8'hA5);
            wr(regs[i], RST_BYTE);
        end
        rd(12'hFFF, RST_BYTE);
        pulse(3'h4, 1'b1);
        pulse(3'h6, 1'b0);
        pulse(3'h1, 1'b1);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CTRL, 8'h00);
        @(posedge clk) srcReq <= 24'h000010;
        repeat (4) @(posedge clk);
        rd(OFS_REQ0, 8'h10);
        @(posedge clk) srcReq <= 24'h000008;
        repeat (4) @(posedge clk);
        srcReq <= 24'h000000;
        rd(OFS_REQ0, 8'h18);
        wr(OFS_EN0_HI, 8'h10);
        wr(OFS_EN0_LO, 8'h10);
        repeat (3) @(posedge clk);
        #1;
        chk(8'(coreIrq), 8'h00);
        pulse(3'h4, 1'b1);
        waitAck(8'h04);
        @(posedge clk);
        #1;
        chk(8'(masterIrqGate), 8'h00);
        rd(OFS_REQ0, 8'h08);
        wr(OFS_REQ0, 8'h00);
        wr(OFS_EN2_HI, 8'h80);
        wr(OFS_EN2_LO, 8'h01);
        @(posedge clk) srcReq <= 24'h810000;
        ackDelay <= 4'h0;
        repeat (4) @(posedge clk);
        srcReq <= 24'h000000;
        wr(OFS_CTRL, 8'h80);
        waitAck(8'h17);
        pulse(3'h1, 1'b1);
        waitAck(8'h10);
        chk(8'(irqOut), 8'h00);
        wr(OFS_IMASK, 8'h02);
        @(posedge clk);
        #1;
        chk(8'(irqOut), 8'h01);
        rd(OFS_ISTAT, 8'h03);
        rd(OFS_ISTAT, 8'h00);
        chk(8'(irqOut), 8'h00);
        rd(OFS_VECTOR, 8'(NO_SRC));
        finish_test();
    end
endmodule
